// ==== dv/test_oscillator_select_status.sv ====
// self-checking bench for the oscillator selection and status block
`timescale 1ns/100ps
module test_oscillator_select_status;
  import oss_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_v;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, req_src = 3'h6, fuse = 3'h0, fast_internal_freq, eff_source;
  logic [3:0]  req_div = 4'h2;
  oss_osc_t    rdy = '0, osc_force_on;
  logic        pll_en = 1'b0, pll_lk = 1'b0, hreadyout, hresp, switch_irq_flag, clock_switched;
  logic        secondary_osc_high_power;
  logic [9:0]  eff_divide_ratio, pll_mult_sel;
  int          err_total = 0, samples_checked = 0, cyc = 0, k;
  logic [2:0]  srcs [8] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h3, 3'h0};
  always #10 clk = ~clk;
  oss_top oss_top_i (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .requested_source_sel(req_src),
    .requested_divider_sel(req_div), .reset_source_fuse(fuse), .osc_ready_in(rdy),
    .pll_enabled(pll_en), .pll_locked(pll_lk), .switch_irq_flag(switch_irq_flag),
    .clock_switched(clock_switched), .osc_force_on(osc_force_on),
    .secondary_osc_high_power(secondary_osc_high_power), .fast_internal_freq(fast_internal_freq),
    .eff_source(eff_source), .eff_divide_ratio(eff_divide_ratio), .pll_mult_sel(pll_mult_sel));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one single-word transfer; the slave may stretch either phase
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
    hsel <= 1'b0;
    check({31'h0, hresp}, 32'h0, "response");
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    check(rd_v, {24'h00_0000, exp}, what);
  endtask
  // request a new setting and wait for the hand-over pulse
  task automatic sw(input logic [2:0] s, input logic [3:0] d);
    int n;
    req_src <= s;
    req_div <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (clock_switched !== 1'b1 && n < 60);
    check({31'h0, clock_switched}, 32'h1, "switch pulse");
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OSS_OFF_CUR, 8'h62, "current after reset");
    rdc(OSS_OFF_FREQ, 8'h06, "freq after reset");
    rdc(OSS_OFF_CTRL, 8'h10, "control after reset");
    rdc(OSS_OFF_FORCE, 8'h00, "force after reset");
    xfer(1'b1, OSS_OFF_CUR, 32'hFFFF_FFFF);
    rdc(OSS_OFF_CUR, 8'h62, "current ignores write");
    xfer(1'b1, 12'h014, 32'hFFFF_FFFF);
    rdc(12'h014, 8'h00, "unmapped");
    rdy <= oss_osc_t'(6'h2A);
    rdc(OSS_OFF_STAT, 8'hA8, "status partial, pll off");
    rdy <= oss_osc_t'(6'h3F);
    pll_en <= 1'b1;
    pll_lk <= 1'b1;
    rdc(OSS_OFF_STAT, 8'hFD, "status all ready");
    pll_lk <= 1'b0;
    rdc(OSS_OFF_STAT, 8'hFC, "status pll unlocked");
    xfer(1'b1, OSS_OFF_FORCE, 32'hFFFF_FFFF);
    rdc(OSS_OFF_FORCE, 8'hFC, "force bits");
    check({26'h0, osc_force_on}, {26'h0, OSS_FORCE_MASK}, "force outputs");
    xfer(1'b1, OSS_OFF_CTRL, 32'h0000_0040);
    rdc(OSS_OFF_CTRL, 8'h50, "power bit");
    check({31'h0, secondary_osc_high_power}, 32'h1, "power output");
    for (k = 0; k < 7; k++) begin
      xfer(1'b1, OSS_OFF_FREQ, 32'hFFFF_FF00 | k);
      rdc(OSS_OFF_FREQ, 8'(k), "freq code");
      check({29'h0, fast_internal_freq}, k, "freq output");
    end
    // switch without hold, new oscillator not yet ready
    rdy <= oss_osc_t'(6'h1F);
    req_src <= OSS_SRC_EXT;
    req_div <= 4'h3;
    rdc(OSS_OFF_CTRL, 8'h40, "switch pending");
    rdc(OSS_OFF_CUR, 8'h62, "current kept while pending");
    rdy <= oss_osc_t'(6'h3F);
    sw(OSS_SRC_EXT, 4'h3);
    rdc(OSS_OFF_CUR, 8'h73, "current after switch");
    rdc(OSS_OFF_CTRL, 8'h50, "done after switch");
    check({22'h0, eff_divide_ratio}, 32'd8, "divide 8");
    // held switch pauses with a flag until hold is cleared
    xfer(1'b1, OSS_OFF_CTRL, 32'h0000_0080);
    req_src <= 3'h0;
    req_div <= 4'h0;
    k = 0;
    while (switch_irq_flag !== 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
    end
    check({31'h0, switch_irq_flag}, 32'h1, "ready flag");
    rdc(OSS_OFF_CTRL, 8'h88, "held status");
    rdc(OSS_OFF_CUR, 8'h73, "current held");
    xfer(1'b1, OSS_OFF_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk);
    rdc(OSS_OFF_CUR, 8'h00, "current after release");
    rdc(OSS_OFF_CTRL, 8'h10, "done after release");
    check({29'h0, eff_source}, {29'h0, OSS_SRC_HF}, "reserved 000 acts as fast");
    // pll sources only become ready once the pll is locked
    pll_lk <= 1'b1;
    for (k = 0; k < 8; k++) begin
      sw(srcs[k], 4'h0);
      check({29'h0, eff_source}, (srcs[k] == 3'h3 || srcs[k] == 3'h0) ? 32'h6 : srcs[k],
            "source decode");
      check({22'h0, pll_mult_sel}, srcs[k] == 3'h2 ? 32'd4 : (srcs[k] == 3'h1 ? 32'd2 : 32'd1),
            "pll multiplier");
    end
    for (k = 1; k <= 10; k++) begin
      sw(3'h0, k % 10);
      check({22'h0, eff_divide_ratio}, 32'h1 << (k % 10), "divide ratio");
    end
    // second reset with the 1 MHz fuse setting
    fuse    <= 3'h6;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OSS_OFF_FREQ, 8'h02, "freq after second reset");
    rdc(OSS_OFF_CUR, 8'h00, "current after second reset");
    rdc(OSS_OFF_CTRL, 8'h10, "control after second reset");
    rdc(OSS_OFF_FORCE, 8'h00, "force after second reset");
    end_sim();
  end
endmodule

// ==== pkg/oss_pkg.sv ====
// constants and types for the oscillator selection and status block
package oss_pkg;
  localparam logic [11:0] OSS_OFF_CUR    = 12'h000;
  localparam logic [11:0] OSS_OFF_CTRL   = 12'h004;
  localparam logic [11:0] OSS_OFF_STAT   = 12'h008;
  localparam logic [11:0] OSS_OFF_FORCE  = 12'h00C;
  localparam logic [11:0] OSS_OFF_FREQ   = 12'h010;
  localparam int OSS_HOLD_BIT = 7;
  localparam int OSS_PWR_BIT  = 6;
  localparam int OSS_DONE_BIT = 4;
  localparam int OSS_NRDY_BIT = 3;
  localparam logic [2:0] OSS_SRC_EXT    = 3'h7;
  localparam logic [2:0] OSS_SRC_HF     = 3'h6;
  localparam logic [2:0] OSS_SRC_LF     = 3'h5;
  localparam logic [2:0] OSS_SRC_SEC    = 3'h4;
  localparam logic [2:0] OSS_SRC_EXTPLL = 3'h2;
  localparam logic [2:0] OSS_SRC_HFPLL  = 3'h1;
  localparam logic [2:0] OSS_FUSE_HF1M  = 3'h6;
  localparam logic [2:0] OSS_FUSE_HF32M = 3'h0;
  localparam logic [2:0] OSS_FRQ_4M     = 3'h2;
  localparam logic [2:0] OSS_FRQ_32M    = 3'h6;
  localparam logic [2:0] OSS_FRQ_RSVD   = 3'h7;
  localparam logic [3:0] OSS_DIV_MAX    = 4'h9;
  localparam logic [5:0] OSS_FORCE_MASK = 6'h3F;
  typedef struct packed {
    logic ext;
    logic hf;
    logic mf;
    logic lf;
    logic sec;
    logic conv;
  } oss_osc_t;
  typedef enum logic [2:0] {
    OSS_ST_IDLE = 3'b001,
    OSS_ST_WAIT = 3'b010,
    OSS_ST_HELD = 3'b100
  } oss_state_t;
endpackage

// ==== rtl/oss_top.sv ====
// oscillator selection, clock switch sequencing and status registers
`timescale 1ns/100ps
module oss_top
  import oss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [2:0]  requested_source_sel,
  input  wire logic [3:0]  requested_divider_sel,
  input  wire logic [2:0]  reset_source_fuse,
  input  wire oss_osc_t    osc_ready_in,
  input  wire logic        pll_enabled,
  input  wire logic        pll_locked,
  output logic             switch_irq_flag,
  output logic             clock_switched,
  output oss_osc_t         osc_force_on,
  output logic             secondary_osc_high_power,
  output logic [2:0]       fast_internal_freq,
  output logic [2:0]       eff_source,
  output logic [9:0]       eff_divide_ratio,
  output logic [9:0]       pll_mult_sel
);
  // source 011 and 000 fold onto 110
  function automatic logic [2:0] oss_norm(input logic [2:0] s);
    oss_norm = (s == 3'h3 || s == 3'h0) ? OSS_SRC_HF : s;
  endfunction

  function automatic logic oss_src_rdy(input logic [2:0] s, input oss_osc_t r, input logic p);
    case (oss_norm(s))
      OSS_SRC_EXT:    oss_src_rdy = r.ext;
      OSS_SRC_HF:     oss_src_rdy = r.hf;
      OSS_SRC_LF:     oss_src_rdy = r.lf;
      OSS_SRC_SEC:    oss_src_rdy = r.sec;
      OSS_SRC_EXTPLL: oss_src_rdy = r.ext & p;
      OSS_SRC_HFPLL:  oss_src_rdy = r.hf & p;
      default:        oss_src_rdy = r.hf;
    endcase
  endfunction

  logic [2:0]  cur_src_r;
  logic [3:0]  cur_div_r;
  logic        hold_r;
  logic        pwr_r;
  logic        nrdy_r;
  logic        init_r;
  oss_osc_t    force_r;
  logic [2:0]  freq_r;
  oss_state_t  st_r;
  oss_state_t  st_nxt;
  logic        ap_wr_r;
  logic [11:0] ap_addr_r;

  // pll input must match the pll source being used
  wire         pll_in_rdy = (oss_norm(requested_source_sel) == OSS_SRC_EXTPLL) ?
                            osc_ready_in.ext : osc_ready_in.hf;
  wire         pll_rdy    = pll_enabled & pll_locked & pll_in_rdy;
  wire         differ     = (requested_source_sel != cur_src_r) ||
                            (requested_divider_sel != cur_div_r);
  wire         new_rdy    = oss_src_rdy(requested_source_sel, osc_ready_in, pll_rdy);
  wire         do_switch  = differ & new_rdy & ~hold_r & ~init_r;
  wire         rise_rdy   = (st_r == OSS_ST_WAIT) & differ & new_rdy;
  wire         ap_take    = hsel & hready & htrans[1];
  wire         wr_en      = ap_wr_r;
  wire [7:0]   wb         = hwdata[7:0];
  wire [7:0]   rd_cur     = {1'b0, cur_src_r, cur_div_r};
  wire [7:0]   rd_ctrl    = {hold_r, pwr_r, 1'b0, ~differ, nrdy_r & differ, 3'b000};
  wire [7:0]   rd_stat    = {osc_ready_in.ext, osc_ready_in.hf, osc_ready_in.mf,
                             osc_ready_in.lf, osc_ready_in.sec, osc_ready_in.conv,
                             1'b0, pll_rdy};
  wire [7:0]   rd_force   = {force_r, 2'b00};
  wire [7:0]   rd_freq    = {5'h00, freq_r};
  // reserved divider codes saturate so the ratio output never wraps to zero
  wire [3:0]   div_sat    = (cur_div_r > OSS_DIV_MAX) ? OSS_DIV_MAX : cur_div_r;
  wire [2:0]   freq_rst   = (reset_source_fuse == OSS_FUSE_HF32M) ? OSS_FRQ_32M : OSS_FRQ_4M;

  // wait collects a pending request; held parks a ready switch until software lets go
  // leaving held needs the request restored or the hold bit cleared
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      OSS_ST_IDLE: if (differ) st_nxt = OSS_ST_WAIT;
      OSS_ST_WAIT: begin
        if (!differ) st_nxt = OSS_ST_IDLE;
        else if (new_rdy && hold_r) st_nxt = OSS_ST_HELD;
        else if (do_switch) st_nxt = OSS_ST_IDLE;
      end
      OSS_ST_HELD: if (!differ || do_switch) st_nxt = OSS_ST_IDLE;
      default: st_nxt = OSS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 12'h000;
      hrdata    <= 32'h0000_0000;
    end else begin
      ap_wr_r   <= ap_take & hwrite;
      ap_addr_r <= ap_take ? haddr[11:0] : ap_addr_r;
      hrdata    <= (ap_take & ~hwrite) ? {24'h00_0000, rd_next(haddr[11:0])} : hrdata;
    end
  end

  // read data is fetched in the address phase so it stands with zero wait
  function automatic logic [7:0] rd_next(input logic [11:0] a);
    rd_next = (a == OSS_OFF_CUR)   ? rd_cur   :
              (a == OSS_OFF_CTRL)  ? rd_ctrl  :
              (a == OSS_OFF_STAT)  ? rd_stat  :
              (a == OSS_OFF_FORCE) ? rd_force :
              (a == OSS_OFF_FREQ)  ? rd_freq  : 8'h00;
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // init_r lets the current fields copy the request on the first edge after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_r    <= 1'b1;
      cur_src_r <= 3'h0;
      cur_div_r <= 4'h0;
      st_r      <= OSS_ST_IDLE;
    end else begin
      init_r <= 1'b0;
      st_r   <= init_r ? OSS_ST_IDLE : st_nxt;
      if (init_r || do_switch) begin
        cur_src_r <= requested_source_sel;
        cur_div_r <= requested_divider_sel;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nrdy_r          <= 1'b0;
      switch_irq_flag <= 1'b0;
      clock_switched  <= 1'b0;
    end else begin
      // hardware clears new-source-ready at the switch; it stays set for as long as a ready switch is held
      nrdy_r          <= differ & new_rdy & ~do_switch & ~init_r;
      switch_irq_flag <= rise_rdy;
      clock_switched  <= do_switch;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_r <= 1'b0;
      pwr_r  <= 1'b0;
    end else if (wr_en && ap_addr_r == OSS_OFF_CTRL) begin
      hold_r <= wb[OSS_HOLD_BIT];
      pwr_r  <= wb[OSS_PWR_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      force_r <= '0;
    end else if (wr_en && ap_addr_r == OSS_OFF_FORCE) begin
      force_r <= wb[7:2] & OSS_FORCE_MASK;
    end
  end

  // fuse is a level caught on the first edge after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freq_r <= OSS_FRQ_4M;
    end else if (init_r) begin
      freq_r <= freq_rst;
    end else if (wr_en && ap_addr_r == OSS_OFF_FREQ) begin
      freq_r <= wb[2:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_force_on             <= '0;
      secondary_osc_high_power <= 1'b0;
      fast_internal_freq       <= OSS_FRQ_4M;
      eff_source               <= OSS_SRC_HF;
      eff_divide_ratio         <= 10'h001;
      pll_mult_sel             <= 10'h000;
    end else begin
      osc_force_on             <= force_r;
      secondary_osc_high_power <= pwr_r;
      fast_internal_freq       <= freq_r;
      eff_source               <= oss_norm(cur_src_r);
      eff_divide_ratio         <= 10'(10'h001 << div_sat);
      pll_mult_sel             <= (oss_norm(cur_src_r) == OSS_SRC_EXTPLL) ? 10'h004 :
                                  (oss_norm(cur_src_r) == OSS_SRC_HFPLL) ? 10'h002 :
                                  10'h001;
    end
  end

  done_equal_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (rd_ctrl[OSS_DONE_BIT] == (requested_source_sel == cur_src_r &&
    requested_divider_sel == cur_div_r))) else $error("done bit mismatch");
  nrdy_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_ctrl[OSS_NRDY_BIT] |-> differ) else $error("ready outside switch");
  hold_blocks_a: assert property (@(posedge clk) disable iff (!reset_n)
    (hold_r && differ && !init_r) |=> $stable(cur_src_r)) else $error("held switch moved");
  switch_done_a: assert property (@(posedge clk) disable iff (!reset_n)
    do_switch |=> (cur_src_r == $past(requested_source_sel)) && clock_switched)
    else $error("switch did not update");
  reset_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
    init_r |=> cur_div_r == $past(requested_divider_sel)) else $error("reset copy lost");
  pll_rdy_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pll_enabled |-> !rd_stat[0]) else $error("pll ready while off");
  irq_pair_a: assert property (@(posedge clk) disable iff (!reset_n)
    rise_rdy |=> switch_irq_flag) else $error("switch flag missing");
  div_ratio_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (cur_div_r == 4'h9) |=> eff_divide_ratio == 10'h200) else $error("bad divide");
  fold_code_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (cur_src_r == 3'h0) |=> eff_source == OSS_SRC_HF) else $error("reserved code");
  freq_rst_a: assert property (@(posedge clk) disable iff (!reset_n)
    (init_r && reset_source_fuse == OSS_FUSE_HF32M) |=> freq_r == OSS_FRQ_32M)
    else $error("freq reset wrong");

  // checks below watch only what this block drives; the request, fuse and
  // ready inputs are free levels from neighbouring logic
  // register images, output copies and the switch sequence each get their own
  // group so a failure points at one path
  // limitation: the bus side is only checked for single word transfers

  // zero wait and okay: masters may rely on it
  bus_okay_a: assert property (@(posedge clk) disable iff (!reset_n)
    hreadyout && !hresp)
    else $error("bus answer not okay");

  // unmapped offsets read back as zero
  read_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    (hsel && hready && htrans[1] && !hwrite && haddr[11:0] > OSS_OFF_FREQ) |=> hrdata == '0)
    else $error("unmapped read not zero");

  // registers are a byte wide; the rest of the word reads zero
  word_upper_a: assert property (@(posedge clk) disable iff (!reset_n)
    hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");

  // software writes never reach the current fields
  cur_ro_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!init_r && !do_switch) |=> $stable(cur_src_r) && $stable(cur_div_r))
    else $error("current moved without switch");

  // the divider follows the request at the switch as well
  switch_div_a: assert property (@(posedge clk) disable iff (!reset_n)
    do_switch |=> cur_div_r == $past(requested_divider_sel))
    else $error("divider not updated");

  // the flag is a one cycle event for the neighbouring flag register
  irq_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    switch_irq_flag |=> !switch_irq_flag)
    else $error("switch flag too long");

  // a held switch shows ready and raises the flag together
  held_ready_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rise_rdy && hold_r) |=> nrdy_r && switch_irq_flag)
    else $error("held ready missing");

  // ready bit is gone once the switch has happened
  nrdy_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    clock_switched |-> !nrdy_r)
    else $error("ready kept after switch");

  // no ready report while the requested source is not ready
  nrdy_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    !new_rdy |=> !nrdy_r)
    else $error("ready before source");

  // only software clears the hold bit
  hold_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    (hold_r && !(wr_en && ap_addr_r == OSS_OFF_CTRL)) |=> hold_r)
    else $error("hold lost");

  // an unlocked pll is never reported ready
  pll_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pll_locked |-> !rd_stat[0])
    else $error("pll ready unlocked");

  // an external pll request needs the external oscillator up
  pll_input_a: assert property (@(posedge clk) disable iff (!reset_n)
    (oss_norm(requested_source_sel) == OSS_SRC_EXTPLL && !osc_ready_in.ext) |-> !rd_stat[0])
    else $error("pll ready without input");

  // external source through the pll multiplies by four
  pll_ext_a: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_src_r == OSS_SRC_EXTPLL) |=> pll_mult_sel == 10'h004)
    else $error("pll x4 wrong");

  // fast internal source through the pll multiplies by two
  pll_fast_a: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_src_r == OSS_SRC_HFPLL) |=> pll_mult_sel == 10'h002)
    else $error("pll x2 wrong");

  // reserved divider codes keep the largest ratio
  div_sat_a: assert property (@(posedge clk) disable iff (!reset_n)
    (cur_div_r > OSS_DIV_MAX) |=> eff_divide_ratio == 10'h200)
    else $error("reserved divide wrong");

  // force bits reach the oscillators one edge after the register
  force_out_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> osc_force_on == $past(force_r))
    else $error("force output lags");

  // power mode reaches the secondary oscillator one edge later
  power_out_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> secondary_osc_high_power == $past(pwr_r))
    else $error("power output lags");

  // frequency code reaches the oscillator one edge later
  freq_out_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> fast_internal_freq == $past(freq_r))
    else $error("freq output lags");

  // any other fuse code starts the fast oscillator at the 4 MHz code
  freq_fuse_a: assert property (@(posedge clk) disable iff (!reset_n)
    (init_r && reset_source_fuse != OSS_FUSE_HF32M) |=> freq_r == OSS_FRQ_4M)
    else $error("freq default wrong");

  // the reset copy happens once only
  init_once_a: assert property (@(posedge clk) disable iff (!reset_n)
    !init_r |=> !init_r)
    else $error("reset copy repeated");

  // the sequencer is always in exactly one state
  state_hot_a: assert property (@(posedge clk) disable iff (!reset_n)
    $onehot(st_r))
    else $error("state not one hot");

  // a written hold bit stands from the next edge
  hold_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_en && ap_addr_r == OSS_OFF_CTRL) |=> hold_r == $past(wb[OSS_HOLD_BIT]))
    else $error("hold write lost");
endmodule
